/* rciu_pkg.sv */
// package for the reset-cause and interrupt unit: register indices,
// field positions, reset values, vectors and carrier types.
// assumes an 8-bit register view reached over a 32-bit classic wishbone.
package rciu_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CAUSE  = 8'h03;  // reset-cause flags
    localparam logic [7:0] IDX_PORT6  = 8'h06;  // port_six_data_reg
    localparam logic [7:0] IDX_STATUS = 8'h0F;  // irq_status_reg
    localparam logic [7:0] IDX_MASK   = 8'h1F;  // irq_mask_reg
    localparam logic [7:0] IDX_CTRL   = 8'h20;  // run state and enable
    localparam int         ADDR_LSB   = 2;

    ////////////////////////////////////////////////////////////////////////
    // irq_status_reg / irq_mask_reg bit positions
    localparam int BIT_TIMER = 0;
    localparam int BIT_PCHG  = 1;  // port_change_flag
    localparam int BIT_EXT   = 2;
    localparam int NUM_SRC   = 3;

    // reset-cause bit positions: pin-change wake, timeout, powerdown
    localparam int BIT_WAKE  = 0;
    localparam int BIT_TOUT  = 1;
    localparam int BIT_PDWN  = 2;

    // control register bit positions
    localparam int BIT_GIE   = 0;
    localparam int BIT_SLEEP = 1;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [2:0] RST_SRC   = 3'h0;
    localparam logic       RST_WAKE  = 1'b0;
    localparam logic       RST_TOUT  = 1'b1;
    localparam logic       RST_PDWN  = 1'b1;
    localparam logic [7:0] RST_PORT6 = 8'hFF;

    // fetch vectors
    localparam int         VEC_W      = 10;
    localparam logic [9:0] VEC_HW     = 10'h008;
    localparam logic [9:0] VEC_SW     = 10'h001;

    ////////////////////////////////////////////////////////////////////////
    // one-cycle instruction strobes from the core
    typedef struct packed {
        logic irqOn;      // global_irq_on_instr
        logic irqOff;     // global_irq_off_instr
        logic retIrq;     // return_from_irq_instr
        logic wdogClear;  // watchdog_clear_instr
        logic sleep;      // sleep_instr
        logic softIrq;    // software interrupt instruction
    } instr_type;

    // redirect of the next fetch
    typedef struct packed {
        logic             take;
        logic [VEC_W-1:0] addr;
    } vector_type;

    // run state of the core as seen by this unit
    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_SLEEP = 1'b1
    } run_type;

endpackage : rciu_pkg

/* reset_cause_and_interrupt_unit.sv */
// reset-cause flags, sleep/wake control and three-source interrupt logic.
// assumes instruction strobes, watchdog expiry and timer overflow come
// from logic on sys_clk; the reset pin and port-six pins are asynchronous.
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps

module reset_cause_and_interrupt_unit #(
    parameter int PORT_W = 8
) (
    // clock and power-on reset
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    // classic wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    // core side
    input  wire rciu_pkg::instr_type     instr,
    output rciu_pkg::vector_type         fetchVector,
    output logic                         coreReset,
    output logic                         wakeUp,
    output logic                         sleeping,
    output logic                         irqPending,
    // event sources
    input  wire logic                    resetPin_n,
    input  wire logic                    watchdogExpire,
    input  wire logic                    timerOverflow,
    input  wire logic [PORT_W-1:0]       portSixPins,
    input  wire logic [PORT_W-1:0]       portSixIsOutput,
    input  wire logic                    extIntSelect
);

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic fallEdge(input logic prev, input logic now);
        fallEdge = prev & ~now;
    endfunction : fallEdge

    // second and third stage must agree before a pin change counts
    function automatic logic filt(input logic s2, input logic s3, input logic old);
        filt = (s2 == s3) ? s3 : old;
    endfunction : filt

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [PORT_W-1:0] p6S1_ff;
    logic [PORT_W-1:0] p6S2_ff;
    logic [PORT_W-1:0] p6S3_ff;
    logic [PORT_W-1:0] p6Filt_ff;
    logic [PORT_W-1:0] nxt_p6Filt;
    logic [2:0]        rstS_ff;
    logic              rstFilt_ff;
    logic              nxt_rstFilt;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            p6S1_ff    <= '1;
            p6S2_ff    <= '1;
            p6S3_ff    <= '1;
            p6Filt_ff  <= '1;
            rstS_ff    <= '1;
            rstFilt_ff <= 1'b1;
        end else begin
            p6S1_ff    <= portSixPins;
            p6S2_ff    <= p6S1_ff;
            p6S3_ff    <= p6S2_ff;
            p6Filt_ff  <= nxt_p6Filt;
            rstS_ff    <= {rstS_ff[1:0], resetPin_n};
            rstFilt_ff <= nxt_rstFilt;
        end
    end

    // per-bit agreement filter on port six
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            nxt_p6Filt[i] = filt(p6S2_ff[i], p6S3_ff[i], p6Filt_ff[i]);
        end
    end
    assign nxt_rstFilt = filt(rstS_ff[1], rstS_ff[2], rstFilt_ff);

    ////////////////////////////////////////////////////////////////////////
    // state registers
    logic [rciu_pkg::NUM_SRC-1:0] status_ff;
    logic [rciu_pkg::NUM_SRC-1:0] mask_ff;
    logic [PORT_W-1:0]            portRef_ff;
    logic                         wakeFlag_ff;
    logic                         toutFlag_ff;
    logic                         pdwnFlag_ff;
    logic                         gie_ff;
    logic                         chgArmed_ff;
    rciu_pkg::run_type            run_ff;
    logic                         extPrev_ff;
    logic                         pinHeld_ff;
    rciu_pkg::vector_type         vec_ff;
    logic                         wake_ff;
    logic                         ack_ff;
    logic [31:0]                  rdat_ff;

    ////////////////////////////////////////////////////////////////////////
    // wishbone decode
    wire        busReq   = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire [7:0]  busIdx   = {{rciu_pkg::ADDR_LSB{1'b0}}, wb_adr_i[7:rciu_pkg::ADDR_LSB]};
    wire        laneOk   = wb_sel_i[0];
    wire        wrReq    = busReq & wb_we_i & laneOk;
    wire        rdReq    = busReq & ~wb_we_i;
    wire        selCause  = (busIdx == rciu_pkg::IDX_CAUSE);
    wire        selPort6  = (busIdx == rciu_pkg::IDX_PORT6);
    wire        selStatus = (busIdx == rciu_pkg::IDX_STATUS);
    wire        selMask   = (busIdx == rciu_pkg::IDX_MASK);
    wire        selCtrl   = (busIdx == rciu_pkg::IDX_CTRL);
    wire        wrStatus  = wrReq & selStatus;
    wire        wrMask    = wrReq & selMask;
    wire        rdPort6   = rdReq & selPort6;
    wire [7:0]  wrByte    = wb_dat_i[7:0];

    ////////////////////////////////////////////////////////////////////////
    // reset events
    wire        asleep     = (run_ff == rciu_pkg::ST_SLEEP);
    wire        pinLow     = ~rstFilt_ff;
    wire        pinEvent   = pinLow & ~pinHeld_ff;
    wire        wdogEvent  = watchdogExpire;
    wire        anyReset   = pinEvent | wdogEvent;

    ////////////////////////////////////////////////////////////////////////
    // interrupt sources: ext on a falling edge, timer on its strobe, change on any difference
    wire        extLevel   = p6Filt_ff[0];
    wire        extEdge    = extIntSelect & fallEdge(extPrev_ff, extLevel);
    wire        timerEdge  = timerOverflow;
    // outputs and the interrupt pin never count as a change
    wire [PORT_W-1:0] chgEligible = ~portSixIsOutput & ~{{(PORT_W-1){1'b0}}, extIntSelect};
    wire [PORT_W-1:0] chgBits     = (p6Filt_ff ^ portRef_ff) & chgEligible;
    wire        chgEnable  = mask_ff[rciu_pkg::BIT_PCHG];
    // unlike the others, the change flag needs its enable
    wire        chgEvent   = (|chgBits) & chgEnable;
    wire [rciu_pkg::NUM_SRC-1:0] setEvents = {extEdge, chgEvent, timerEdge};

    // wake needs change armed at the sleep instruction
    wire        pinWake    = asleep & chgEvent & chgArmed_ff;

    ////////////////////////////////////////////////////////////////////////
    // request and vector selection
    wire [rciu_pkg::NUM_SRC-1:0] reqBits = status_ff & mask_ff;
    wire        hwReq      = (|reqBits) & gie_ff & ~asleep;
    wire        swReq      = instr.softIrq & gie_ff & ~asleep;
    wire        takeAny    = hwReq | swReq;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, set wins over a software write
    logic [rciu_pkg::NUM_SRC-1:0] nxt_status;
    assign nxt_status = anyReset ? rciu_pkg::RST_SRC
                      : ((wrStatus ? wrByte[rciu_pkg::NUM_SRC-1:0] : status_ff)
                         | setEvents);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_ff <= rciu_pkg::RST_SRC;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // mask register, cleared by pin or watchdog reset
    logic [rciu_pkg::NUM_SRC-1:0] nxt_mask;
    assign nxt_mask = anyReset ? rciu_pkg::RST_SRC
                    : (wrMask ? wrByte[rciu_pkg::NUM_SRC-1:0] : mask_ff);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_ff <= rciu_pkg::RST_SRC;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // change reference, captured when software reads port six
    logic [PORT_W-1:0] nxt_portRef;
    assign nxt_portRef = rdPort6 ? p6Filt_ff : portRef_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            portRef_ff <= rciu_pkg::RST_PORT6;
        end else begin
            portRef_ff <= nxt_portRef;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset-cause flags; later events in this chain take priority
    logic nxt_wake;
    logic nxt_tout;
    logic nxt_pdwn;

    always_comb begin
        nxt_wake = wakeFlag_ff;
        nxt_tout = toutFlag_ff;
        nxt_pdwn = pdwnFlag_ff;
        if (instr.wdogClear) begin
            nxt_tout = 1'b1;
            nxt_pdwn = 1'b1;
        end
        if (instr.sleep && !asleep) begin
            nxt_tout = 1'b1;
            nxt_pdwn = 1'b0;
        end
        if (pinWake) begin
            nxt_wake = 1'b1;
            nxt_tout = 1'b1;
            nxt_pdwn = 1'b0;
        end
        if (wdogEvent) begin
            nxt_wake = 1'b0;
            nxt_tout = 1'b0;
            if (asleep) begin
                nxt_pdwn = 1'b0;
            end
        end
        if (pinEvent) begin
            nxt_wake = 1'b0;
            if (asleep) begin
                nxt_tout = 1'b1;
                nxt_pdwn = 1'b0;
            end
        end
    end

    // power-on values
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wakeFlag_ff <= rciu_pkg::RST_WAKE;
            toutFlag_ff <= rciu_pkg::RST_TOUT;
            pdwnFlag_ff <= rciu_pkg::RST_PDWN;
        end else begin
            wakeFlag_ff <= nxt_wake;
            toutFlag_ff <= nxt_tout;
            pdwnFlag_ff <= nxt_pdwn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // global enable; taking a vector clears it until a return or irq-on instruction
    logic nxt_gie;
    assign nxt_gie = anyReset ? 1'b0
                   : takeAny ? 1'b0
                   : (instr.irqOn | instr.retIrq) ? 1'b1
                   : instr.irqOff ? 1'b0
                   : gie_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gie_ff <= 1'b0;
        end else begin
            gie_ff <= nxt_gie;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // run state and armed change wake
    rciu_pkg::run_type nxt_run;
    logic              nxt_armed;

    always_comb begin
        nxt_run   = run_ff;
        nxt_armed = chgArmed_ff;
        case (run_ff)
            rciu_pkg::ST_RUN: begin
                if (instr.sleep && !anyReset) begin
                    nxt_run   = rciu_pkg::ST_SLEEP;
                    nxt_armed = chgEnable;
                end
            end
            rciu_pkg::ST_SLEEP: begin
                if (anyReset || pinWake) begin
                    nxt_run   = rciu_pkg::ST_RUN;
                    nxt_armed = 1'b0;
                end
            end
            default: begin
                nxt_run   = rciu_pkg::ST_RUN;
                nxt_armed = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_ff      <= rciu_pkg::ST_RUN;
            chgArmed_ff <= 1'b0;
        end else begin
            run_ff      <= nxt_run;
            chgArmed_ff <= nxt_armed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge history and reset-pin hold so a long low counts once
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            extPrev_ff <= 1'b1;
            pinHeld_ff <= 1'b0;
        end else begin
            extPrev_ff <= extLevel;
            pinHeld_ff <= pinLow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fetch redirect; hardware vector wins a same-cycle tie
    rciu_pkg::vector_type nxt_vec;
    always_comb begin
        nxt_vec.take = takeAny & ~anyReset;
        nxt_vec.addr = hwReq ? rciu_pkg::VEC_HW : rciu_pkg::VEC_SW;
    end

    // wake pulse; with the enable set the pending request vectors next
    logic nxt_wakePulse;
    assign nxt_wakePulse = pinWake & ~anyReset;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            vec_ff  <= '0;
            wake_ff <= 1'b0;
        end else begin
            vec_ff  <= nxt_vec;
            wake_ff <= nxt_wakePulse;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone answer, one wait state
    logic [31:0] rdMux;
    always_comb begin
        rdMux = '0;
        if (selCause) begin
            rdMux[rciu_pkg::BIT_WAKE] = wakeFlag_ff;
            rdMux[rciu_pkg::BIT_TOUT] = toutFlag_ff;
            rdMux[rciu_pkg::BIT_PDWN] = pdwnFlag_ff;
        end else if (selPort6) begin
            rdMux[PORT_W-1:0] = p6Filt_ff;
        end else if (selStatus) begin
            rdMux[rciu_pkg::NUM_SRC-1:0] = status_ff;
        end else if (selMask) begin
            rdMux[rciu_pkg::NUM_SRC-1:0] = mask_ff;
        end else if (selCtrl) begin
            rdMux[rciu_pkg::BIT_GIE]   = gie_ff;
            rdMux[rciu_pkg::BIT_SLEEP] = asleep;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff  <= 1'b0;
            rdat_ff <= '0;
        end else begin
            ack_ff  <= busReq;
            rdat_ff <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign wb_ack_o    = ack_ff;
    assign wb_dat_o    = rdat_ff;
    assign fetchVector = vec_ff;
    assign wakeUp      = wake_ff;
    assign sleeping    = asleep;
    assign irqPending  = |reqBits;
    assign coreReset   = pinLow | wdogEvent;

endmodule : reset_cause_and_interrupt_unit

/* rciu_checker.sv */
// checker for the reset-cause unit: bus, vector and wake timing
// assumes it is bound to the unit and sees only the unit's ports
`timescale 1ns/1ps

module rciu_checker (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 reset_n,
    // bus handshake
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_ack_o,
    // core side
    input wire rciu_pkg::instr_type  instr,
    input wire rciu_pkg::vector_type fetchVector,
    input wire logic                 coreReset,
    input wire logic                 wakeUp,
    input wire logic                 sleeping,
    input wire logic                 irqPending,
    // event sources
    input wire logic                 watchdogExpire
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    // ack one cycle after a request, for one cycle
    wb_answer_a : assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    ack_pulse_a : assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    ////////////////////////////////////////////////////////////////////////
    // one-cycle redirect to the two fixed vectors
    take_pulse_a : assert property (fetchVector.take |=> !fetchVector.take)
        else $error("vector take longer than one cycle");
    vec_addr_a : assert property (fetchVector.take |->
        fetchVector.addr == rciu_pkg::VEC_HW || fetchVector.addr == rciu_pkg::VEC_SW)
        else $error("vector address not a fetch vector");
    hw_cause_a : assert property (fetchVector.take &&
        fetchVector.addr == rciu_pkg::VEC_HW |-> $past(irqPending))
        else $error("hw vector with no request");
    // disable, quiet cycle, then no vector
    irq_off_a : assert property (instr.irqOff ##1 instr == '0 |=> !fetchVector.take)
        else $error("vector taken with global enable off");

    ////////////////////////////////////////////////////////////////////////
    // reset, sleep and wake
    wdog_reset_a : assert property (watchdogExpire |-> coreReset)
        else $error("watchdog did not reset core");
    wdog_clear_a : assert property (watchdogExpire |=> !sleeping && !irqPending)
        else $error("watchdog reset left sleep or request");
    sleep_enter_a : assert property (instr.sleep && !sleeping && !coreReset |=> sleeping)
        else $error("sleep did not enter sleep");
    wake_run_a : assert property (wakeUp |-> !sleeping)
        else $error("wake pulse while still asleep");
    wake_pulse_a : assert property (wakeUp |=> !wakeUp)
        else $error("wake pulse longer than one cycle");

endmodule : rciu_checker

bind reset_cause_and_interrupt_unit rciu_checker i_rciu_checker (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .wb_cyc_i       (wb_cyc_i),
    .wb_stb_i       (wb_stb_i),
    .wb_ack_o       (wb_ack_o),
    .instr          (instr),
    .fetchVector    (fetchVector),
    .coreReset      (coreReset),
    .wakeUp         (wakeUp),
    .sleeping       (sleeping),
    .irqPending     (irqPending),
    .watchdogExpire (watchdogExpire)
);

/* core_pin_model.sv */
// model of the core's fetch side: records every redirect and wake-up
// assumes take and wake are one-cycle pulses on sys_clk
`timescale 1ns/1ps

module core_pin_model (
    // clock
    input wire logic                          sys_clk,
    // unit outputs seen by the core
    input wire rciu_pkg::vector_type          fetchVector,
    input wire logic                          wakeUp,
    // what the core saw
    output int                                takeCount,
    output logic [rciu_pkg::VEC_W-1:0]        lastAddr,
    output int                                wakeCount
);
    initial begin
        takeCount = 0;
        wakeCount = 0;
        lastAddr = '0;
    end

    // counted, not levelled: a stuck take would show as extra fetches
    always @(posedge sys_clk) begin
        if (fetchVector.take === 1'b1) begin
            takeCount <= takeCount + 1;
            lastAddr <= fetchVector.addr;
        end
        if (wakeUp === 1'b1) begin
            wakeCount <= wakeCount + 1;
        end
    end
endmodule : core_pin_model

/* reset_cause_and_interrupt_unit_tb_top.sv */
// self-checking bench for the reset-cause and interrupt unit
// assumes the bus answers in a few cycles, pins sync in under 8
`timescale 1ns/1ps

module reset_cause_and_interrupt_unit_tb_top;
    typedef struct packed {
        logic [2:0] act;  // 0 sleep, 1 watchdog, 2 clear, 3 pin
        logic [2:0] cause;
        logic       slp;
    } row_type;
    localparam int NROW = 7;
    localparam row_type ROWS [NROW] = '{
        '{3'h0, 3'h2, 1'h1},  // sleep from run
        '{3'h1, 3'h0, 1'h0},  // watchdog while asleep
        '{3'h2, 3'h6, 1'h0},  // watchdog clear
        '{3'h1, 3'h4, 1'h0},  // watchdog while running
        '{3'h3, 3'h4, 1'h0},  // pin while running
        '{3'h0, 3'h2, 1'h1},  // sleep again
        '{3'h3, 3'h2, 1'h0}   // pin while asleep
    };

    logic                 sys_clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 wbCyc, wbStb, wbWe, wbAck;
    logic [7:0]           wbAdr;
    logic [31:0]          wbDatI, wbDatO, rd;
    rciu_pkg::instr_type  instr;
    rciu_pkg::vector_type fetchVector;
    logic                 coreReset, wakeUp, sleeping, irqPending;
    logic                 resetPin_n, watchdogExpire, timerOverflow;
    logic [7:0]           portSixPins;
    logic [9:0]           lastAddr;
    int                   takeCount, wakeCount;
    int                   failures = 0;
    int                   checks = 0;
    int                   cycles = 0;

    always #4 sys_clk = ~sys_clk;

    reset_cause_and_interrupt_unit #(.PORT_W(8)) i_reset_cause_and_interrupt_unit (
        .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .instr(instr), .fetchVector(fetchVector),
        .coreReset(coreReset), .wakeUp(wakeUp), .sleeping(sleeping),
        .irqPending(irqPending), .resetPin_n(resetPin_n), .watchdogExpire(watchdogExpire),
        .timerOverflow(timerOverflow), .portSixPins(portSixPins),
        .portSixIsOutput(8'h02), .extIntSelect(1'b1));

    core_pin_model i_core_pin_model (.sys_clk(sys_clk), .fetchVector(fetchVector),
        .wakeUp(wakeUp), .takeCount(takeCount), .lastAddr(lastAddr), .wakeCount(wakeCount));

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // a hang ends in the same report
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            failures = failures + 1;
            results();
        end
    end

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // request held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx[5:0], 2'h0};
        wbDatI <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        check("ack", 32'h1, {31'h0, wbAck});
    endtask : wb

    task automatic rdChk(string what, logic [7:0] idx, logic [31:0] exp);
        wb(1'b0, idx, 32'h0);
        check(what, exp, rd);
    endtask : rdChk

    task automatic pulse(input logic [5:0] v);
        @(posedge sys_clk);
        instr <= rciu_pkg::instr_type'(v);
        @(posedge sys_clk);
        instr <= '0;
    endtask : pulse

    task automatic srcPulse(input logic wdog);
        @(posedge sys_clk);
        watchdogExpire <= wdog;
        timerOverflow <= !wdog;
        @(posedge sys_clk);
        watchdogExpire <= 1'b0;
        timerOverflow <= 1'b0;
    endtask : srcPulse

    // one row action; for a pin row, pin low past the filter
    task automatic doEvent(input logic [2:0] act);
        case (act)
            3'h0: pulse(6'h02);
            3'h1: srcPulse(1'b1);
            3'h2: pulse(6'h04);
            default: begin
                @(posedge sys_clk);
                resetPin_n <= 1'b0;
                repeat (6) @(posedge sys_clk);
                resetPin_n <= 1'b1;
            end
        endcase
        repeat (8) @(posedge sys_clk);
    endtask : doEvent

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI} = '0;
        instr = '0;
        {watchdogExpire, timerOverflow} = 2'h0;
        resetPin_n = 1'b1;
        portSixPins = 8'hFF;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdChk("cause", rciu_pkg::IDX_CAUSE, 32'h6);
        for (int i = 0; i < NROW; i++) begin
            doEvent(ROWS[i].act);
            rdChk("cause", rciu_pkg::IDX_CAUSE, {29'h0, ROWS[i].cause});
            check("sleeping", {31'h0, ROWS[i].slp}, {31'h0, sleeping});
        end
        // mid-run power-on, read-only and unmapped
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdChk("cause", rciu_pkg::IDX_CAUSE, 32'h6);
        rdChk("status", rciu_pkg::IDX_STATUS, 32'h0);
        rdChk("mask", rciu_pkg::IDX_MASK, 32'h0);
        rdChk("ctrl", rciu_pkg::IDX_CTRL, 32'h0);
        wb(1'b1, rciu_pkg::IDX_CAUSE, 32'h0);
        rdChk("cause ro", rciu_pkg::IDX_CAUSE, 32'h6);
        wb(1'b1, 8'h3F, 32'hFF);
        rdChk("unmapped", 8'h3F, 32'h0);
        // timer flag sets while masked; unmask vectors
        pulse(6'h20);
        srcPulse(1'b0);
        repeat (2) @(posedge sys_clk);
        rdChk("status", rciu_pkg::IDX_STATUS, 32'h1);
        check("pending", 32'h0, {31'h0, irqPending});
        check("no take", 32'h0, takeCount);
        wb(1'b1, rciu_pkg::IDX_MASK, 32'h1);
        repeat (3) @(posedge sys_clk);
        check("hw take", 32'h1, takeCount);
        check("hw vector", 32'h8, {22'h0, lastAddr});
        rdChk("gie", rciu_pkg::IDX_CTRL, 32'h0);
        wb(1'b1, rciu_pkg::IDX_STATUS, 32'h0);
        pulse(6'h08);
        repeat (3) @(posedge sys_clk);
        rdChk("gie ret", rciu_pkg::IDX_CTRL, 32'h1);
        check("one take", 32'h1, takeCount);
        pulse(6'h01);
        repeat (3) @(posedge sys_clk);
        check("sw take", 32'h2, takeCount);
        check("sw vector", 32'h1, {22'h0, lastAddr});
        pulse(6'h20);
        pulse(6'h10);
        pulse(6'h01);
        repeat (3) @(posedge sys_clk);
        check("refused", 32'h2, takeCount);
        // ext pin falls; flag sets though masked
        @(posedge sys_clk);
        portSixPins <= 8'hFE;
        repeat (8) @(posedge sys_clk);
        rdChk("ext flag", rciu_pkg::IDX_STATUS, 32'h4);
        // change wake; output and interrupt pins excluded
        wb(1'b1, rciu_pkg::IDX_STATUS, 32'h0);
        rdChk("reference", rciu_pkg::IDX_PORT6, 32'hFE);
        wb(1'b1, rciu_pkg::IDX_MASK, 32'h2);
        pulse(6'h02);
        @(posedge sys_clk);
        portSixPins <= 8'hFD;
        repeat (8) @(posedge sys_clk);
        check("excluded", 32'h1, {31'h0, sleeping});
        portSixPins <= 8'hED;
        repeat (8) @(posedge sys_clk);
        check("wake", 32'h1, wakeCount);
        check("inline", 32'h2, takeCount);
        check("awake", 32'h0, {31'h0, sleeping});
        rdChk("wake cause", rciu_pkg::IDX_CAUSE, 32'h3);
        results();
    end
endmodule : reset_cause_and_interrupt_unit_tb_top
